// ===== rtl/src_consts.vh
`ifndef SRC_CONSTS_VH
`define SRC_CONSTS_VH
// Reset request vector bit positions
`define SRC_NSRC        8
`define SRC_B_POR       0
`define SRC_B_PIN       1
`define SRC_B_CMP       2
`define SRC_B_SW        3
`define SRC_B_MON       4
`define SRC_B_WDT       5
`define SRC_B_MCD       6
`define SRC_B_FLASH     7
// Timing at 100 MHz
`define SRC_CLK_MHZ     100
`define SRC_PIN_MIN_US  15
`define SRC_DELAY_US    50
`define SRC_PIN_CYC     (`SRC_PIN_MIN_US * `SRC_CLK_MHZ)
`define SRC_DELAY_CYC   (`SRC_DELAY_US * `SRC_CLK_MHZ)
// Start-up values
`define SRC_PC_RESET    16'h0000
`define SRC_CLK_INTOSC  2'h0
`define SRC_CAUSE_POR   8'h01
`define SRC_CNT_W       13
`define SRC_SYNC_W      2
`endif

// ===== rtl/src_sync.v
`default_nettype none
// Two-flop level synchroniser; first stage feeds only the second
module src_sync #(
   parameter W = 8
) (
   input  wire         clock_i,
   input  wire         reset_i,
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
      end else begin
         s1_reg <= d_i;
         s2_reg <= s1_reg;
      end
   end
   assign q_o = s2_reg;
endmodule // src_sync
`default_nettype wire

// ===== rtl/src_reset_ctrl.v
`include "src_consts.vh"
`default_nettype none
// How it works
// - Core run enable stays low whenever any reset is in effect.
// - Module reset on entry; power-on-only reset solely on power-on.
// - Interrupt and timer enables drop while in reset.
// - RAM gets no reset; its keep-contents flag stays high.
// - Default ports: latches high, open-drain, weak pull-ups on throughout.
// - Retention keeps port state except on power-on.
// - Supply monitor or power-on reset drives the reset pin low until exit.
// - Instruction pointer reloads to zero on leaving reset.
// - Clock select forced to internal oscillator on leaving reset.
// - Watchdog enabled and running on leaving reset.
// - Any of eight requesters enters reset.
// - Execution resumes 50 us after a non-power-on source releases.
module src_reset_ctrl #(
   parameter PIN_CYC   = `SRC_PIN_CYC,
   parameter DELAY_CYC = `SRC_DELAY_CYC
) (
   input  wire        clock_i,
   input  wire        reset_i,
   input  wire        cmp_reset_i,
   input  wire        sw_reset_i,
   input  wire        supply_low_i,
   input  wire        wdt_reset_i,
   input  wire        missing_clk_i,
   input  wire        flash_err_i,
   input  wire        external_reset_pin_n_i,
   input  wire        retain_enable_i,
   output reg         external_reset_pin_n_o,
   output reg         external_reset_pin_n_oe_o,
   output reg         core_run_o,
   output reg         sys_reset_o,
   output reg         por_reset_o,
   output reg         irq_enable_o,
   output reg         timer_enable_o,
   output reg         ram_keep_o,
   output reg         port_latch_high_o,
   output reg         port_open_drain_o,
   output reg         port_pullup_en_o,
   output reg         io_retain_o,
   output reg  [15:0] instruction_pointer_o,
   output reg  [1:0]  clock_select_o,
   output reg         wdt_enable_o,
   output reg  [7:0]  reset_cause_o
);
   localparam ST_POR  = 2'h0;
   localparam ST_HOLD = 2'h1;
   localparam ST_WAIT = 2'h2;
   localparam ST_RUN  = 2'h3;
   localparam integer PIN_LAST = PIN_CYC - 1;
   localparam integer DLY_LAST = DELAY_CYC - 1;
   localparam [`SRC_CNT_W-1:0] PIN_MAX = PIN_LAST[`SRC_CNT_W-1:0];
   localparam [`SRC_CNT_W-1:0] DLY_MAX = DLY_LAST[`SRC_CNT_W-1:0];

   wire [7:0] raw_req;
   wire [7:0] req;
   reg  [1:0] state_reg;
   reg  [1:0] state_next;
   reg  [`SRC_CNT_W-1:0] pin_cnt_reg;
   reg  [`SRC_CNT_W-1:0] dly_cnt_reg;
   reg  [`SRC_CNT_W-1:0] dly_cnt_next;
   reg        pin_req_reg;
   reg        por_seen_reg;
   reg        drive_pin_reg;
   wire       any_req;
   wire       in_reset;

   // Retention is void until the power-on sequence has run once
   function keep_io;
      input retain_en;
      input por_open;
      begin
         keep_io = retain_en & ~por_open;
      end
   endfunction

   // Pin is low-true; debounce applied after synchronising
   assign raw_req = {flash_err_i, missing_clk_i, wdt_reset_i, supply_low_i,
                     sw_reset_i, cmp_reset_i, ~external_reset_pin_n_i,
                     1'b0};

   src_sync #(.W(`SRC_NSRC)) u_sync (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .d_i     (raw_req),
      .q_o     (req)
   );

   // Pin counts only after 15 us low, so glitches and our own drive
   // echo are filtered; our echo is masked since drive_pin marks it
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         pin_cnt_reg <= {`SRC_CNT_W{1'b0}};
         pin_req_reg <= 1'b0;
      end else if (req[`SRC_B_PIN] && !drive_pin_reg) begin
         if (pin_cnt_reg == PIN_MAX) begin
            pin_req_reg <= 1'b1;
         end else begin
            pin_cnt_reg <= pin_cnt_reg + 1'b1;
         end
      end else begin
         pin_cnt_reg <= {`SRC_CNT_W{1'b0}};
         pin_req_reg <= 1'b0;
      end
   end

   assign any_req = pin_req_reg | req[`SRC_B_CMP] | req[`SRC_B_SW] |
                    req[`SRC_B_MON] | req[`SRC_B_WDT] | req[`SRC_B_MCD] |
                    req[`SRC_B_FLASH];
   // Outputs follow the next state so they move with the state register
   assign in_reset = (state_next != ST_RUN);

   // A request during the wait restarts the hold, so the delay counts
   // from the last source to drop
   always @* begin
      state_next   = state_reg;
      dly_cnt_next = dly_cnt_reg;
      case (state_reg)
         ST_POR: begin
            state_next   = ST_HOLD;
         end
         ST_HOLD: begin
            dly_cnt_next = {`SRC_CNT_W{1'b0}};
            if (!any_req) begin
               state_next = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (any_req) begin
               state_next = ST_HOLD;
            end else if (dly_cnt_reg == DLY_MAX) begin
               state_next = ST_RUN;
            end else begin
               dly_cnt_next = dly_cnt_reg + 1'b1;
            end
         end
         ST_RUN: begin
            if (any_req) begin
               state_next = ST_HOLD;
            end
         end
         default: begin
            state_next = ST_POR;
         end
      endcase
   end

   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg     <= ST_POR;
         dly_cnt_reg   <= {`SRC_CNT_W{1'b0}};
         por_seen_reg  <= 1'b1;
         drive_pin_reg <= 1'b1;
      end else begin
         state_reg   <= state_next;
         dly_cnt_reg <= dly_cnt_next;
         if (state_next == ST_RUN) begin
            por_seen_reg  <= 1'b0;
            drive_pin_reg <= 1'b0;
         end else if (req[`SRC_B_MON]) begin
            drive_pin_reg <= 1'b1;
         end
      end
   end

   // Outputs, all registered; asynchronous reset gives power-on state
   always @(posedge clock_i or posedge reset_i) begin
      if (reset_i) begin
         external_reset_pin_n_o    <= 1'b0;
         external_reset_pin_n_oe_o <= 1'b1;
         core_run_o            <= 1'b0;
         sys_reset_o           <= 1'b1;
         por_reset_o           <= 1'b1;
         irq_enable_o          <= 1'b0;
         timer_enable_o        <= 1'b0;
         ram_keep_o            <= 1'b1;
         port_latch_high_o     <= 1'b1;
         port_open_drain_o     <= 1'b1;
         port_pullup_en_o      <= 1'b1;
         io_retain_o           <= 1'b0;
         instruction_pointer_o <= `SRC_PC_RESET;
         clock_select_o        <= `SRC_CLK_INTOSC;
         wdt_enable_o          <= 1'b1;
         reset_cause_o         <= `SRC_CAUSE_POR;
      end else begin
         external_reset_pin_n_o    <= 1'b0;
         external_reset_pin_n_oe_o <= in_reset &
            (drive_pin_reg | req[`SRC_B_MON]);
         core_run_o  <= ~in_reset;
         sys_reset_o <= in_reset;
         por_reset_o <= in_reset & por_seen_reg;
         if (in_reset) begin
            irq_enable_o   <= 1'b0;
            timer_enable_o <= 1'b0;
            // Retention honoured only away from power-on
            io_retain_o <= keep_io(retain_enable_i, por_seen_reg);
            if (!keep_io(retain_enable_i, por_seen_reg)) begin
               port_latch_high_o <= 1'b1;
               port_open_drain_o <= 1'b1;
            end
            instruction_pointer_o <= `SRC_PC_RESET;
            clock_select_o        <= `SRC_CLK_INTOSC;
            wdt_enable_o          <= 1'b1;
            if (state_reg == ST_RUN) begin
               reset_cause_o <= {req[`SRC_B_FLASH:`SRC_B_CMP],
                                 pin_req_reg, 1'b0};
            end
         end else begin
            irq_enable_o   <= 1'b1;
            timer_enable_o <= 1'b1;
            io_retain_o    <= 1'b0;
            // Ports go back to firmware; the latch itself keeps its value
            port_latch_high_o <= 1'b0;
            port_open_drain_o <= 1'b0;
         end
         ram_keep_o       <= 1'b1;
         port_pullup_en_o <= 1'b1;
      end
   end
endmodule // src_reset_ctrl
`default_nettype wire

// ===== sim/src_pin_agent.sv
`default_nettype none
module src_pin_agent (
   input  wire logic       clock_i,
   input  wire logic       go_i,
   input  wire logic [7:0] len_i,
   output wire logic       low_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] left_reg = 8'h00;
   // Short holds are issued on purpose to probe the glitch filter
   always @(posedge clock_i) begin
      if (go_i) left_reg <= len_i;
      else if (left_reg != 8'h00) left_reg <= left_reg - 8'h01;
   end
   assign low_o = (left_reg != 8'h00);
endmodule // src_pin_agent
`default_nettype wire

// ===== sim/src_reset_ctrl_chk.sv
`default_nettype none
module src_reset_ctrl_chk (
   input wire logic        clock_i,
   input wire logic        reset_i,
   input wire logic        sw_reset_i,
   input wire logic        supply_low_i,
   input wire logic        external_reset_pin_n_o,
   input wire logic        external_reset_pin_n_oe_o,
   input wire logic        core_run_o,
   input wire logic        sys_reset_o,
   input wire logic        por_reset_o,
   input wire logic        irq_enable_o,
   input wire logic        timer_enable_o,
   input wire logic        ram_keep_o,
   input wire logic        port_latch_high_o,
   input wire logic        port_open_drain_o,
   input wire logic        port_pullup_en_o,
   input wire logic        io_retain_o,
   input wire logic [15:0] instruction_pointer_o,
   input wire logic [1:0]  clock_select_o,
   input wire logic        wdt_enable_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   a_core_halt: assert property (sys_reset_o |-> !core_run_o)
      else $error("core runs in reset");
   a_por_nested: assert property (por_reset_o |-> sys_reset_o)
      else $error("por reset alone");
   a_irq_off: assert property (sys_reset_o |->
      !(irq_enable_o | timer_enable_o))
      else $error("irq or timer on in reset");
   a_ram_kept: assert property (ram_keep_o && port_pullup_en_o)
      else $error("ram or pullup dropped");
   a_port_dflt: assert property (sys_reset_o && !io_retain_o |->
      port_latch_high_o && port_open_drain_o) else $error("port state");
   a_retain_ok: assert property (io_retain_o |-> !por_reset_o)
      else $error("retain in por");
   a_por_pin: assert property (por_reset_o |->
      external_reset_pin_n_oe_o && !external_reset_pin_n_o)
      else $error("pin not driven");
   a_mon_pin: assert property ($rose(supply_low_i) |-> ##[1:6]
      external_reset_pin_n_oe_o) else $error("monitor pin");
   a_start_ok: assert property ($rose(core_run_o) |->
      wdt_enable_o && instruction_pointer_o == 16'h0000 &&
      clock_select_o == 2'h0) else $error("start state");
   a_sw_enter: assert property ($rose(sw_reset_i) |->
      ##[1:6] sys_reset_o) else $error("no reset entry");
   a_sync_exit: assert property ($fell(sys_reset_o) |-> core_run_o)
      else $error("exit not aligned");
   c_restart: cover property ($rose(core_run_o));
   c_retain: cover property (io_retain_o);
   c_pin: cover property ($rose(external_reset_pin_n_oe_o));
endmodule // src_reset_ctrl_chk
bind src_reset_ctrl src_reset_ctrl_chk chk (.*);
`default_nettype wire

// ===== sim/tb_src_reset_ctrl.sv
`default_nettype none
module tb_src_reset_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PC = 4;
   localparam int DC = 8;
   logic clock_i = 1'b0, reset_i = 1'b1, retain = 1'b0, go = 1'b0;
   logic [7:0] req = 8'h00, len = 8'h00;
   wire [7:0] cause;
   wire pin_o, pin_oe, run, srst, por, retn, low, pin;
   int err_total = 0, tests_run = 0, cyc = 0;
   logic [7:0] exp_q[$];
   always #5 clock_i = ~clock_i;
   // Pull-up wire: either party may pull it low
   assign pin = ~((pin_oe & ~pin_o) | low);
   src_pin_agent agt (.clock_i(clock_i), .go_i(go), .len_i(len), .low_o(low));
   src_reset_ctrl #(.PIN_CYC(PC), .DELAY_CYC(DC)) dut (
      .clock_i(clock_i), .reset_i(reset_i), .cmp_reset_i(req[2]),
      .sw_reset_i(req[3]), .supply_low_i(req[4]), .wdt_reset_i(req[5]),
      .missing_clk_i(req[6]), .flash_err_i(req[7]),
      .external_reset_pin_n_i(pin), .retain_enable_i(retain),
      .external_reset_pin_n_o(pin_o), .external_reset_pin_n_oe_o(pin_oe),
      .core_run_o(run), .sys_reset_o(srst), .por_reset_o(por),
      .irq_enable_o(), .timer_enable_o(), .ram_keep_o(),
      .port_latch_high_o(), .port_open_drain_o(), .port_pullup_en_o(),
      .io_retain_o(retn), .instruction_pointer_o(), .clock_select_o(),
      .wdt_enable_o(), .reset_cause_o(cause));
   task automatic chk(input bit ok, input string m);
      tests_run++;
      if (!ok) begin
         err_total++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Source b requested for n cycles; the model predicts the outcome
   task automatic hit(input int b, input int n);
      bit rs = 0, oe = 0, rt = 0, r = 1'($urandom % 2);
      int up = -1;
      logic [7:0] c = 8'h00;
      bit want = (b != 1 || n >= PC);
      if (want) exp_q.push_back(8'(1 << b));
      @(posedge clock_i);
      retain <= r;
      go <= (b == 1);
      len <= 8'(n);
      if (b != 1) req[b] <= 1'b1;
      for (int t = 0; t < n + DC + 30; t++) begin
         @(posedge clock_i);
         go <= 1'b0;
         if (t == n - 1) req <= 8'h00;
         #1;
         if (srst === 1'b1 && !rs) c = cause;
         if (srst === 1'b1) rs = 1;
         if (pin_oe === 1'b1) oe = 1;
         if (retn === 1'b1) rt = 1;
         if (rs && up < 0 && run === 1'b1) up = t - n;
      end
      chk(rs == want, "entry");
      if (rs && exp_q.size() != 0) begin
         chk(c === exp_q.pop_front(), "cause");
         chk(oe == (b == 4), "pin drive");
         chk(rt == r, "retain");
         chk(up >= DC && up <= DC + 8, "restart delay");
      end
   endtask
   always @(posedge clock_i) begin
      cyc++;
      if (cyc > 2000) begin
         err_total++;
         summarize();
      end
   end
   initial begin
      void'($urandom(8));
      repeat (16) @(posedge clock_i);
      #1;
      chk(por === 1'b1 && pin_oe === 1'b1 && run === 1'b0, "por");
      @(posedge clock_i) reset_i <= 1'b0;
      repeat (DC + 20) @(posedge clock_i);
      #1;
      chk(run === 1'b1 && pin_oe === 1'b0, "por exit");
      for (int b = 2; b < 8; b++) hit(b, 1 + $urandom % 3);
      hit(1, PC + 2 + $urandom % 3);
      hit(1, 2);
      // Power-on again in mid-run: retention must be ignored
      @(posedge clock_i);
      retain  <= 1'b1;
      reset_i <= 1'b1;
      repeat (3) @(posedge clock_i);
      reset_i <= 1'b0;
      repeat (4) @(posedge clock_i);
      #1;
      chk(por === 1'b1 && retn === 1'b0 && run === 1'b0, "por retain");
      chk(pin_oe === 1'b1, "por pin");
      repeat (DC + 20) @(posedge clock_i);
      #1;
      chk(run === 1'b1 && pin_oe === 1'b0, "por restart");
      summarize();
   end
endmodule // tb_src_reset_ctrl
`default_nettype wire
